//--- dual_bridge_chopper_control.sv
`timescale 1ns/100ps
`include "bridge_consts.svh"
module dual_bridge_chopper_control (
   input  wire logic       CLOCK_I,
   input  wire logic       RST_I,
   input  wire logic [1:0] BRIDGE_ENABLE_I,
   input  wire logic [1:0] BRIDGE_DIRECTION_I,
   input  wire logic [1:0] CURRENT_SCALE_HI_I,
   input  wire logic [1:0] CURRENT_SCALE_LO_I,
   input  wire logic [1:0] SENSE_TRIP_I,
   input  wire logic [1:0] CURRENT_ZERO_I,
   input  wire logic       DECAY_SELECT_HIGH_I,
   input  wire logic       DECAY_SELECT_OPEN_I,
   input  wire logic       LOGIC_CLEAR_LOW_I,
   input  wire logic       STANDBY_REQUEST_LOW_I,
   input  wire logic [1:0] OVERCURRENT_I,
   input  wire logic       OVER_TEMP_I,
   input  wire logic       MOTOR_SUPPLY_LOW_I,
   output logic [1:0]      WINDING_OUT_A_HI_O,
   output logic [1:0]      WINDING_OUT_A_LO_O,
   output logic [1:0]      WINDING_OUT_B_HI_O,
   output logic [1:0]      WINDING_OUT_B_LO_O,
   output logic [1:0]      WINDING_OUT_A_OE_O,
   output logic [1:0]      WINDING_OUT_B_OE_O,
   output logic            FAULT_FLAG_LOW_O,
   output logic            FAULT_FLAG_LOW_OE_O,
   output logic            CHARGE_PUMP_RUN_O,
   output logic            AUX_REGULATOR_ON_O,
   output logic            READY_O
);
   localparam int SYNC_W = 15;
   logic [SYNC_W-1:0] s1_reg;
   logic [SYNC_W-1:0] s2_reg;
   logic [SYNC_W-1:0] raw;
   logic [1:0]  en_s, dir_s, shi_s, slo_s, trip_s, zero_s, oc_s;
   logic        dhi_s, dopen_s, clr_n_s, sleep_n_s, ot_s, uv_s;
   logic        clr;
   logic        run;
   logic [8:0]  pwm_reg;
   logic        cycle_start_reg;
   logic        mixed_pt_reg;
   logic        oc_latch_reg;
   logic [15:0] wake_reg;
   bridge_pkg::decay_e decay;
   logic [1:0]  ah, al, bh, bl, drv;

   assign raw = {BRIDGE_ENABLE_I, BRIDGE_DIRECTION_I, CURRENT_SCALE_HI_I,
                 CURRENT_SCALE_LO_I, SENSE_TRIP_I, CURRENT_ZERO_I,
                 DECAY_SELECT_HIGH_I, DECAY_SELECT_OPEN_I,
                 LOGIC_CLEAR_LOW_I};
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         s1_reg <= 15'h0;
         s2_reg <= 15'h0;
      end else begin
         s1_reg <= raw;
         s2_reg <= s1_reg;
      end
   end
   assign {en_s, dir_s, shi_s, slo_s, trip_s, zero_s, dhi_s, dopen_s,
           clr_n_s} = s2_reg;

   logic [4:0] p1_reg;
   logic [4:0] p2_reg;
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         p1_reg <= 5'h0;
         p2_reg <= 5'h0;
      end else begin
         p1_reg <= {STANDBY_REQUEST_LOW_I, OVERCURRENT_I, OVER_TEMP_I,
                    MOTOR_SUPPLY_LOW_I};
         p2_reg <= p1_reg;
      end
   end
   assign {sleep_n_s, oc_s, ot_s, uv_s} = p2_reg;

   assign clr = RST_I || !clr_n_s || uv_s
                || !sleep_n_s;
   assign run = !oc_latch_reg && !ot_s
                && wake_reg == 16'h0;

   always_ff @(posedge CLOCK_I) begin
      if (clr) wake_reg <= 16'(`WAKE_CYCLES);
      else if (wake_reg != 16'h0) wake_reg <= wake_reg - 16'h1;
   end

   always_ff @(posedge CLOCK_I) begin
      if (clr) oc_latch_reg <= 1'b0;
      else if (|oc_s) oc_latch_reg <= 1'b1;
   end

   always_ff @(posedge CLOCK_I) begin
      if (clr) begin
         pwm_reg <= 9'h0;
         cycle_start_reg <= 1'b0;
         mixed_pt_reg <= 1'b0;
      end else begin
         pwm_reg <= (pwm_reg == 9'(`PWM_CYCLES - 1)) ? 9'h0
                    : pwm_reg + 9'h1;
         cycle_start_reg <= (pwm_reg == 9'(`PWM_CYCLES - 1));
         mixed_pt_reg <= (pwm_reg == 9'(`MIXED_CYCLES - 1));
      end
   end

   always_comb begin
      if (dopen_s) decay = bridge_pkg::DECAY_MIXED;
      else if (dhi_s) decay = bridge_pkg::DECAY_FAST;
      else decay = bridge_pkg::DECAY_SLOW;
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ch
         bridge_channel u_ch (
            .clk_i         (CLOCK_I),
            .clr_i         (clr || !run),
            .cycle_start_i (cycle_start_reg),
            .mixed_point_i (mixed_pt_reg),
            .decay_i       (decay),
            .enable_i      (en_s[g]),
            .direction_i   (dir_s[g]),
            .scale_i       ({shi_s[g], slo_s[g]}),
            .trip_i        (trip_s[g]),
            .zero_i        (zero_s[g]),
            .a_hi_o        (ah[g]),
            .a_lo_o        (al[g]),
            .b_hi_o        (bh[g]),
            .b_lo_o        (bl[g]),
            .drive_o       (drv[g])
         );
      end
   endgenerate

   always_ff @(posedge CLOCK_I) begin
      if (clr) begin
         WINDING_OUT_A_HI_O <= 2'h0;
         WINDING_OUT_A_LO_O <= 2'h0;
         WINDING_OUT_B_HI_O <= 2'h0;
         WINDING_OUT_B_LO_O <= 2'h0;
         WINDING_OUT_A_OE_O <= 2'h0;
         WINDING_OUT_B_OE_O <= 2'h0;
      end else begin
         WINDING_OUT_A_HI_O <= ah;
         WINDING_OUT_A_LO_O <= al;
         WINDING_OUT_B_HI_O <= bh;
         WINDING_OUT_B_LO_O <= bl;
         WINDING_OUT_A_OE_O <= (ah | al) & drv;
         WINDING_OUT_B_OE_O <= (bh | bl) & drv;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         FAULT_FLAG_LOW_O    <= 1'b0;
         FAULT_FLAG_LOW_OE_O <= 1'b0;
         CHARGE_PUMP_RUN_O   <= 1'b0;
         AUX_REGULATOR_ON_O  <= 1'b0;
         READY_O             <= 1'b0;
      end else begin
         FAULT_FLAG_LOW_O    <= 1'b0;
         FAULT_FLAG_LOW_OE_O <= sleep_n_s
            && (oc_latch_reg || ot_s);
         CHARGE_PUMP_RUN_O   <= sleep_n_s && !uv_s;
         AUX_REGULATOR_ON_O  <= sleep_n_s && !uv_s;
         READY_O             <= !clr && wake_reg == 16'h0;
      end
   end

   property p_fault_oc;
      @(posedge CLOCK_I) disable iff (clr)
      oc_latch_reg |=> FAULT_FLAG_LOW_OE_O;
   endproperty
   a_fault_oc: assert property (p_fault_oc)
      else $error("overcurrent not flagged");
   property p_clear_off;
      @(posedge CLOCK_I) disable iff (RST_I)
      !clr_n_s |=> (WINDING_OUT_A_OE_O == 2'h0 && WINDING_OUT_B_OE_O == 2'h0);
   endproperty
   a_clear_off: assert property (p_clear_off)
      else $error("bridges driven during clear");
   property p_sleep_off;
      @(posedge CLOCK_I) disable iff (RST_I)
      !sleep_n_s |=> !CHARGE_PUMP_RUN_O && !AUX_REGULATOR_ON_O;
   endproperty
   a_sleep_off: assert property (p_sleep_off)
      else $error("pump or regulator on in standby");
   property p_scale_off;
      @(posedge CLOCK_I) disable iff (RST_I)
      (shi_s[0] && slo_s[0])[*3] |=> WINDING_OUT_A_OE_O[0] == 1'b0;
   endproperty
   a_scale_off: assert property (p_scale_off)
      else $error("bridge driven at scale off");
   property p_period;
      @(posedge CLOCK_I) disable iff (clr)
      cycle_start_reg |=> !cycle_start_reg [*8];
   endproperty
   a_period: assert property (p_period)
      else $error("pwm cycle too short");
   property p_wake;
      @(posedge CLOCK_I) disable iff (RST_I)
      $rose(sleep_n_s) |=> !READY_O [*8];
   endproperty
   a_wake: assert property (p_wake)
      else $error("ready too soon after standby");
   c_fault: cover property (@(posedge CLOCK_I) FAULT_FLAG_LOW_OE_O);
   c_drive: cover property (@(posedge CLOCK_I) WINDING_OUT_A_OE_O[0]);
   c_slow: cover property (@(posedge CLOCK_I) &WINDING_OUT_A_LO_O);
endmodule : dual_bridge_chopper_control

//--- bridge_consts.svh
`ifndef BRIDGE_CONSTS_SVH
`define BRIDGE_CONSTS_SVH
`define CLK_MHZ          25
`define PWM_KHZ          50
`define PWM_CYCLES       (`CLK_MHZ * 1000 / `PWM_KHZ)
`define BLANK_NS         3750
`define BLANK_CYCLES     ((`BLANK_NS * `CLK_MHZ + 999) / 1000)
`define MIXED_PCT        75
`define MIXED_CYCLES     (`PWM_CYCLES * `MIXED_PCT / 100)
`define DEAD_NS          400
`define DEAD_CYCLES      ((`DEAD_NS * `CLK_MHZ + 999) / 1000)
`define WAKE_US          1000
`define WAKE_CYCLES      (`WAKE_US * `CLK_MHZ)
`define SCALE_FULL       2'h0
`define SCALE_71         2'h1
`define SCALE_38         2'h2
`define SCALE_OFF        2'h3
`endif

//--- bridge_pkg.sv
package bridge_pkg;
   typedef enum logic [1:0] {
      DECAY_SLOW  = 2'h0,
      DECAY_MIXED = 2'h1,
      DECAY_FAST  = 2'h2
   } decay_e;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_DRIVE = 4'h2,
      ST_FAST  = 4'h4,
      ST_SLOW  = 4'h8
   } phase_e;
endpackage : bridge_pkg

//--- bridge_channel.sv
`timescale 1ns/100ps
`include "bridge_consts.svh"
module bridge_channel (
   input  wire logic               clk_i,
   input  wire logic               clr_i,
   input  wire logic               cycle_start_i,
   input  wire logic               mixed_point_i,
   input  wire bridge_pkg::decay_e decay_i,
   input  wire logic               enable_i,
   input  wire logic               direction_i,
   input  wire logic [1:0]         scale_i,
   input  wire logic               trip_i,
   input  wire logic               zero_i,
   output logic                    a_hi_o,
   output logic                    a_lo_o,
   output logic                    b_hi_o,
   output logic                    b_lo_o,
   output logic                    drive_o
);
   bridge_pkg::phase_e st_reg;
   logic [7:0]         blank_reg;
   logic [3:0]         dead_reg;
   logic [3:0]         want_reg;
   logic [3:0]         want_next;
   logic               on_ok;

   assign on_ok = enable_i && (scale_i != `SCALE_OFF);
   always_ff @(posedge clk_i) begin
      if (clr_i) begin
         st_reg <= bridge_pkg::ST_IDLE;
      end else if (!on_ok) begin
         st_reg <= bridge_pkg::ST_IDLE;
      end else if (cycle_start_i) begin
         st_reg <= bridge_pkg::ST_DRIVE;
      end else begin
         case (st_reg)
            bridge_pkg::ST_DRIVE: begin
               if (trip_i && blank_reg == 8'h0) begin
                  if (decay_i == bridge_pkg::DECAY_SLOW)
                     st_reg <= bridge_pkg::ST_SLOW;
                  else
                     st_reg <= bridge_pkg::ST_FAST;
               end
            end
            bridge_pkg::ST_FAST: begin
               if (decay_i == bridge_pkg::DECAY_MIXED && mixed_point_i)
                  st_reg <= bridge_pkg::ST_SLOW;
               else if (zero_i)
                  st_reg <= bridge_pkg::ST_IDLE;
            end
            default: st_reg <= st_reg;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (clr_i || st_reg != bridge_pkg::ST_DRIVE ||
          {a_hi_o, a_lo_o, b_hi_o, b_lo_o} != want_next)
         blank_reg <= 8'(`BLANK_CYCLES);
      else if (blank_reg != 8'h0)
         blank_reg <= blank_reg - 8'h1;
   end

   // order: a_hi, a_lo, b_hi, b_lo
   always_comb begin
      case (st_reg)
         bridge_pkg::ST_DRIVE:
            want_next = direction_i ? 4'h9 : 4'h6;
         bridge_pkg::ST_FAST:
            want_next = direction_i ? 4'h6 : 4'h9;
         bridge_pkg::ST_SLOW: want_next = 4'h5;
         default:             want_next = 4'h0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (clr_i) begin
         want_reg <= 4'h0;
         dead_reg <= 4'h0;
         {a_hi_o, a_lo_o, b_hi_o, b_lo_o} <= 4'h0;
      end else if (want_next != want_reg) begin
         want_reg <= want_next;
         dead_reg <= 4'(`DEAD_CYCLES);
         {a_hi_o, a_lo_o, b_hi_o, b_lo_o} <=
            {a_hi_o, a_lo_o, b_hi_o, b_lo_o} & want_next;
      end else if (dead_reg != 4'h0) begin
         dead_reg <= dead_reg - 4'h1;
      end else begin
         {a_hi_o, a_lo_o, b_hi_o, b_lo_o} <= want_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (clr_i) drive_o <= 1'b0;
      else drive_o <= on_ok;
   end

   property p_blank_hold;
      @(posedge clk_i) disable iff (clr_i)
      $rose(st_reg == bridge_pkg::ST_DRIVE) && !cycle_start_i |->
         (st_reg == bridge_pkg::ST_DRIVE || !on_ok)[*8];
   endproperty
   a_blank_hold: assert property (p_blank_hold)
      else $error("trip acted inside blanking");
   property p_never_shoot;
      @(posedge clk_i) disable iff (clr_i)
      !(a_hi_o && a_lo_o) && !(b_hi_o && b_lo_o);
   endproperty
   a_never_shoot: assert property (p_never_shoot)
      else $error("both switches of a half on");
endmodule : bridge_channel

//--- motor_winding_model.sv
`timescale 1ns/100ps
module motor_winding_model (
   input  wire logic       clk_i,
   input  wire logic [1:0] a_hi_i,
   input  wire logic [1:0] a_lo_i,
   input  wire logic [1:0] b_hi_i,
   input  wire logic [1:0] b_lo_i,
   input  wire logic [1:0] scale_hi_i,
   input  wire logic [1:0] scale_lo_i,
   input  wire logic       trip_now_i,
   output logic [1:0]      trip_o,
   output logic [1:0]      zero_o
);
   int cur [2];
   int lim [2];
   initial cur = '{0, 0};
   // winding current, signed by direction
   always @(posedge clk_i) begin
      for (int b = 0; b < 2; b++) begin
         if (a_hi_i[b] && b_lo_i[b])
            cur[b] <= cur[b] + 1;
         else if (b_hi_i[b] && a_lo_i[b])
            cur[b] <= cur[b] - 1;
         else if (!(a_lo_i[b] && b_lo_i[b]))
            cur[b] <= (cur[b] > 0) ? cur[b] - 1
                      : (cur[b] < 0) ? cur[b] + 1 : 0;
      end
   end
   // both low sides on: current holds
   always_comb begin
      for (int b = 0; b < 2; b++) begin
         case ({scale_hi_i[b], scale_lo_i[b]})
            2'h0: lim[b] = 200;
            2'h1: lim[b] = 142;
            2'h2: lim[b] = 76;
            default: lim[b] = 0;
         endcase
         trip_o[b] = trip_now_i || cur[b] >= lim[b]
                     || -cur[b] >= lim[b];
         zero_o[b] = cur[b] < 2 && cur[b] > -2;
      end
   end
endmodule : motor_winding_model

//--- dual_bridge_chopper_control_tb.sv
`timescale 1ns/100ps
`include "bridge_consts.svh"
module dual_bridge_chopper_control_tb;
   logic       clk;
   logic       rst;
   logic [1:0] en;
   logic [1:0] dir;
   logic [1:0] shi;
   logic [1:0] slo;
   logic [1:0] trip;
   logic [1:0] zero;
   logic [1:0] ocur;
   logic       dec_hi;
   logic       dec_open;
   logic       clr_n;
   logic       stby_n;
   logic       hot;
   logic       sup_low;
   logic       trip_now;
   logic [1:0] ahi;
   logic [1:0] alo;
   logic [1:0] bhi;
   logic [1:0] blo;
   logic [1:0] aoe;
   logic [1:0] boe;
   logic       flt;
   logic       flt_oe;
   logic       cp;
   logic       aux;
   logic       rdy;
   logic       fw;
   logic       clr_acc;
   logic [6:0] acc;
   logic [9:0] obs;
   logic [9:0] exp_q [$];
   logic [9:0] msk_q [$];
   string      nam_q [$];
   int         on_cnt;
   int         bad_count;
   int         checked;
   int         n;

   dual_bridge_chopper_control i_dual_bridge_chopper_control (
      .CLOCK_I(clk), .RST_I(rst), .BRIDGE_ENABLE_I(en),
      .BRIDGE_DIRECTION_I(dir), .CURRENT_SCALE_HI_I(shi),
      .CURRENT_SCALE_LO_I(slo), .SENSE_TRIP_I(trip), .CURRENT_ZERO_I(zero),
      .DECAY_SELECT_HIGH_I(dec_hi), .DECAY_SELECT_OPEN_I(dec_open),
      .LOGIC_CLEAR_LOW_I(clr_n), .STANDBY_REQUEST_LOW_I(stby_n),
      .OVERCURRENT_I(ocur), .OVER_TEMP_I(hot), .MOTOR_SUPPLY_LOW_I(sup_low),
      .WINDING_OUT_A_HI_O(ahi), .WINDING_OUT_A_LO_O(alo),
      .WINDING_OUT_B_HI_O(bhi), .WINDING_OUT_B_LO_O(blo),
      .WINDING_OUT_A_OE_O(aoe), .WINDING_OUT_B_OE_O(boe),
      .FAULT_FLAG_LOW_O(flt), .FAULT_FLAG_LOW_OE_O(flt_oe),
      .CHARGE_PUMP_RUN_O(cp), .AUX_REGULATOR_ON_O(aux), .READY_O(rdy));

   motor_winding_model i_motor_winding_model (
      .clk_i(clk), .a_hi_i(ahi), .a_lo_i(alo), .b_hi_i(bhi), .b_lo_i(blo),
      .scale_hi_i(shi), .scale_lo_i(slo), .trip_now_i(trip_now),
      .trip_o(trip), .zero_o(zero));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   assign fw = ahi[0] & blo[0];
   // window flags: oe0 fwd rev slow bad - oe1
   always @(posedge clk) begin
      if (clr_acc) begin
         acc    <= '0;
         on_cnt <= 0;
      end else begin
         acc[0] <= acc[0] | aoe[0] | boe[0];
         acc[1] <= acc[1] | fw;
         acc[2] <= acc[2] | (bhi[0] & alo[0]);
         acc[3] <= acc[3] | (alo[0] & blo[0]);
         acc[4] <= acc[4] | flt | |((ahi & alo) | (bhi & blo));
         acc[6] <= acc[6] | aoe[1] | boe[1];
         on_cnt <= on_cnt + int'(fw);
      end
   end
   assign obs = {rdy, cp & aux, flt_oe, acc[6],
                 on_cnt >= `BLANK_CYCLES && on_cnt <= `BLANK_CYCLES + 10,
                 acc[4:0]};

   task automatic check(input string what, input logic [9:0] seen,
                        input logic [9:0] expv);
      checked++;
      if (seen !== expv) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, expv, seen);
      end
   endtask : check

   task automatic conclude;
      if (bad_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude

   task automatic note(input string what, input logic [9:0] m,
                       input logic [9:0] e);
      nam_q.push_back(what);
      msk_q.push_back(m);
      exp_q.push_back(e & m);
   endtask : note

   task automatic measure(input string what, input logic [9:0] m,
                          input logic [9:0] e, input int settle);
      repeat (settle) @(negedge clk);
      clr_acc = 1'b1;
      @(negedge clk);
      clr_acc = 1'b0;
      repeat (`PWM_CYCLES) @(negedge clk);
      note(what, m, e);
   endtask : measure

   task automatic wait_ready;
      for (int i = 0; i < 30000 && rdy !== 1'b1; i++) @(negedge clk);
      note("wake", 10'h380, 10'h300);
   endtask : wait_ready

   // compares each noted expectation with the outputs
   initial begin
      forever begin
         wait (nam_q.size() != 0);
         check(nam_q.pop_front(), obs & msk_q.pop_front(), exp_q.pop_front());
      end
   end

   initial begin
      repeat (98000) @(posedge clk);
      bad_count++;
      conclude();
   end

   initial begin
      void'($urandom(32'h4630cff8));
      {rst, clr_acc, clr_n, stby_n} = 4'hf;
      {en, dir, shi, slo, ocur} = '0;
      {dec_hi, dec_open, hot, sup_low, trip_now} = '0;
      bad_count = 0;
      checked = 0;
      repeat (6) @(negedge clk);
      note("reset", 10'h380, 10'h000);
      rst = 1'b0;
      wait_ready();
      en = 2'b11;
      dir = {1'($urandom), 1'b1};
      measure("dir one", 10'h013, 10'h003, 600);
      dir[0] = 1'b0;
      measure("dir zero", 10'h017, 10'h005, 600);
      dir[0] = 1'b1;
      for (int s = 0; s < 4; s++) begin
         {shi[0], slo[0]} = 2'(s);
         {shi[1], slo[1]} = 2'($urandom);
         measure("scale", 10'h003, s == 3 ? 10'h0 : 10'h3, 600);
      end
      {shi, slo} = '0;
      trip_now = 1'b1;
      measure("blanking", 10'h020, 10'h020, 600);
      trip_now = 1'b0;
      for (int d = 0; d < 3; d++) begin
         {dec_open, dec_hi} = 2'(d == 2 ? 2 : d);
         n = 2 | (d != 0) << 2 | (d != 1) << 3;
         measure("decay", 10'h01e, 10'(n),
                 600);
      end
      {dec_open, dec_hi} = 2'b00;
      repeat (600) @(negedge clk);
      for (int i = 0; i < 600 && fw; i++) @(negedge clk);
      for (int i = 0; i < 600 && !fw; i++) @(negedge clk);
      n = 0;
      for (int i = 0; i < 600 && fw; i++) begin @(negedge clk); n++; end
      for (int i = 0; i < 600 && !fw; i++) begin @(negedge clk); n++; end
      check("period", 10'(n), 10'(`PWM_CYCLES));
      en = 2'b10;
      measure("bridge one only", 10'h041, 10'h040, 600);
      en = 2'b11;
      {shi[1], slo[1]} = 2'b11;
      measure("bridge one off", 10'h041, 10'h001, 600);
      {shi[1], slo[1]} = 2'b00;
      hot = 1'b1;
      measure("hot", 10'h0c1, 10'h080, 20);
      hot = 1'b0;
      measure("cooled", 10'h0c1, 10'h041, 600);
      ocur = 2'b01;
      repeat (20) @(negedge clk);
      ocur = 2'b00;
      measure("overcurrent", 10'h0c1, 10'h080, 20);
      clr_n = 1'b0;
      measure("clear held", 10'h041, 10'h000, 20);
      clr_n = 1'b1;
      repeat (10) @(negedge clk);
      note("fault cleared", 10'h080, 10'h000);
      wait_ready();
      sup_low = 1'b1;
      measure("supply low", 10'h141, 10'h000, 20);
      sup_low = 1'b0;
      wait_ready();
      stby_n = 1'b0;
      dir = ~dir;
      measure("standby", 10'h141, 10'h000, 20);
      @(negedge clk);
      conclude();
   end
endmodule : dual_bridge_chopper_control_tb
